// *** hdl/spp_pkg.sv ***
package spp_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  // Each index is a word slot; the byte address is four times the index
  localparam int unsigned ADDR_W = 18;

  localparam logic [15:0] IDX_PORT_PIN_LEVEL       = 16'hF210;
  localparam logic [15:0] IDX_PORT_PIN_DIRECTION   = 16'hF211;
  localparam logic [15:0] IDX_PIN_DRIVE_CONFIG_LOW  = 16'hF212;
  localparam logic [15:0] IDX_PIN_DRIVE_CONFIG_HIGH = 16'hF213;
  localparam logic [15:0] IDX_PIN_FUNC_SELECT_LOW   = 16'hF214;
  localparam logic [15:0] IDX_PIN_FUNC_SELECT_HIGH  = 16'hF215;
  localparam logic [15:0] IDX_PIN_DRIVE_CONFIG_WORD = 16'hF218;
  localparam logic [15:0] IDX_PIN_FUNC_SELECT_WORD  = 16'hF219;

  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam int unsigned PIN_COUNT  = 6;

  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [1:0] CFG_HIZ   = 2'h0;
  localparam logic [1:0] CFG_PCH   = 2'h1;
  localparam logic [1:0] CFG_NCH   = 2'h2;
  localparam logic [1:0] CFG_CMOS  = 2'h3;
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic       DIR_OUT   = 1'b0;

  // Per pin, one bit per function code that is prohibited (pin 5 first)
  localparam logic [5:0][3:0] FUNC_BAD = {4'hC, 4'hC, 4'h4, 4'h0, 4'h0, 4'h0};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SPP_REG_LEVEL, SPP_REG_DIR, SPP_REG_CFG_LO, SPP_REG_CFG_HI,
    SPP_REG_FSEL_LO, SPP_REG_FSEL_HI, SPP_REG_CFG_WORD, SPP_REG_FSEL_WORD,
    SPP_REG_NONE
  } spp_reg_e;

  typedef struct packed {
    logic       dir;
    logic [1:0] cfg;
    logic [1:0] func;
    logic [3:0] func_bad;
  } spp_pin_ctl_s;

  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull_up;
    logic pull_down;
  } spp_pad_s;

endpackage : spp_pkg

// *** hdl/spp_pin_cell.sv ***
module spp_pin_cell (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire spp_pkg::spp_pin_ctl_s ctl,
  input  wire logic                  level,
  output spp_pkg::spp_pad_s          pad
);

  spp_pkg::spp_pad_s pad_d;
  spp_pkg::spp_pad_s pad_q;

  // ************************************************************
  // Pad decode
  // ************************************************************
  always_comb begin
    pad_d      = '{out: level, oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b0};
    if (ctl.func != spp_pkg::FUNC_GPIO) begin
      // Prohibited codes in output mode drive the pad low with drive codes 10 and 11, else release it; other codes hand it over
      if (ctl.func_bad[ctl.func] && ctl.dir == spp_pkg::DIR_OUT) begin
        pad_d.out  = 1'b0;
        pad_d.oe_n = !ctl.cfg[1];
      end
    end else if (ctl.dir == spp_pkg::DIR_OUT) begin
      unique case (ctl.cfg)
        spp_pkg::CFG_HIZ:  pad_d.oe_n = 1'b1;
        spp_pkg::CFG_PCH:  pad_d.oe_n = !level;
        spp_pkg::CFG_NCH:  pad_d.oe_n = level;
        spp_pkg::CFG_CMOS: pad_d.oe_n = 1'b0;
      endcase
    end else begin
      // Input direction reads the same code as termination
      pad_d.pull_down = (ctl.cfg == spp_pkg::CFG_PCH);
      pad_d.pull_up   = (ctl.cfg == spp_pkg::CFG_NCH);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_q <= '{out: 1'b0, oe_n: 1'b1, pull_up: 1'b0, pull_down: 1'b0};
    end else begin
      pad_q <= pad_d;
    end
  end

  assign pad = pad_q;

endmodule : spp_pin_cell

// *** hdl/spp_port.sv ***
// How it works
// - An output pin with function code 00 (GPIO) drives its bit of the level register as its drive code selects; drive code 00 leaves it hi-z.
// - Output-direction bits read back exactly as written.
// - Input-direction bits read the live pin level instead.
// - Level register bits five to zero, one per pin, 0 low and 1 high.
// - Direction bit 0 is output, 1 is input; all reset to output.
// - Direction is its own 8-bit read/write register one slot above level, reset zero.
// - For a GPIO pin the two-bit drive code means drive style or termination by direction.
// - Output codes: 00 hi-z, 01 P-channel open drain, 10 N-channel, 11 CMOS.
// - Input codes: 00 hi-z, 01 pull-down, 10 pull-up, 11 hi-z.
// - All drive codes reset to 00, so pins start as hi-z outputs.
// - Drive config reachable as two bytes or one 16-bit word, reset zero.
// - Each pin has one drive bit per config byte at its pin position.
// - Six consecutive read/write byte registers, all resetting to zero.
// - Function select holds a two-bit code per pin; 00 means GPIO.
module spp_port #(
  parameter int unsigned PINS = spp_pkg::PIN_COUNT
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [spp_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                 awprot,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [spp_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                 arprot,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic [PINS-1:0]            pad_in,
  output logic [PINS-1:0]                 pad_out,
  output logic [PINS-1:0]                 pad_oe_n,
  output logic [PINS-1:0]                 pad_pull_up,
  output logic [PINS-1:0]                 pad_pull_down,
  output logic [2*PINS-1:0]               pin_function_code
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic spp_pkg::spp_reg_e reg_of(input logic [spp_pkg::ADDR_W-1:0] a);
    logic [15:0] idx;
    idx = a[spp_pkg::ADDR_W-1:2];
    unique case (idx)
      spp_pkg::IDX_PORT_PIN_LEVEL:        reg_of = spp_pkg::SPP_REG_LEVEL;
      spp_pkg::IDX_PORT_PIN_DIRECTION:    reg_of = spp_pkg::SPP_REG_DIR;
      spp_pkg::IDX_PIN_DRIVE_CONFIG_LOW:  reg_of = spp_pkg::SPP_REG_CFG_LO;
      spp_pkg::IDX_PIN_DRIVE_CONFIG_HIGH: reg_of = spp_pkg::SPP_REG_CFG_HI;
      spp_pkg::IDX_PIN_FUNC_SELECT_LOW:   reg_of = spp_pkg::SPP_REG_FSEL_LO;
      spp_pkg::IDX_PIN_FUNC_SELECT_HIGH:  reg_of = spp_pkg::SPP_REG_FSEL_HI;
      spp_pkg::IDX_PIN_DRIVE_CONFIG_WORD: reg_of = spp_pkg::SPP_REG_CFG_WORD;
      spp_pkg::IDX_PIN_FUNC_SELECT_WORD:  reg_of = spp_pkg::SPP_REG_FSEL_WORD;
      default:                            reg_of = spp_pkg::SPP_REG_NONE;
    endcase
  endfunction : reg_of

  // Two-bit code of one pin, split across a low and a high byte
  function automatic logic [1:0] pair_of(input logic [7:0] hi, input logic [7:0] lo,
                                         input int unsigned pin);
    pair_of = {hi[pin], lo[pin]};
  endfunction : pair_of

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] level_q, level_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] cfg_lo_q, cfg_lo_d;
  logic [7:0] cfg_hi_q, cfg_hi_d;
  logic [7:0] fsel_lo_q, fsel_lo_d;
  logic [7:0] fsel_hi_q, fsel_hi_d;

  logic                       aw_full_q, aw_full_d;
  logic                       w_full_q, w_full_d;
  logic [spp_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]                wdata_q, wdata_d;
  logic [3:0]                 wstrb_q, wstrb_d;
  logic                       bvalid_q, bvalid_d;
  logic [1:0]                 bresp_q, bresp_d;
  logic                       rvalid_q, rvalid_d;
  logic [1:0]                 rresp_q, rresp_d;
  logic [31:0]                rdata_q, rdata_d;
  logic                       do_wr;
  logic [7:0]                 level_view;
  spp_pkg::spp_reg_e          wsel;
  spp_pkg::spp_reg_e          rsel;

  // ************************************************************
  // Write channel
  // ************************************************************
  // Write address and data are held apart so either may arrive first
  assign awready = !aw_full_q && !bvalid_q;
  assign wready  = !w_full_q && !bvalid_q;
  assign do_wr   = aw_full_q && w_full_q;
  assign wsel    = reg_of(awaddr_q);

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    level_d   = level_q;
    dir_d     = dir_q;
    cfg_lo_d  = cfg_lo_q;
    cfg_hi_d  = cfg_hi_q;
    fsel_lo_d = fsel_lo_q;
    fsel_hi_d = fsel_hi_q;
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      awaddr_d  = awaddr;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      wdata_d  = wdata;
      wstrb_d  = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wsel == spp_pkg::SPP_REG_NONE) ? spp_pkg::RESP_SLVERR : spp_pkg::RESP_OKAY;
      unique case (wsel)
        spp_pkg::SPP_REG_LEVEL:   if (wstrb_q[0]) level_d   = wdata_q[7:0];
        spp_pkg::SPP_REG_DIR:     if (wstrb_q[0]) dir_d     = wdata_q[7:0];
        spp_pkg::SPP_REG_CFG_LO:  if (wstrb_q[0]) cfg_lo_d  = wdata_q[7:0];
        spp_pkg::SPP_REG_CFG_HI:  if (wstrb_q[0]) cfg_hi_d  = wdata_q[7:0];
        spp_pkg::SPP_REG_FSEL_LO: if (wstrb_q[0]) fsel_lo_d = wdata_q[7:0];
        spp_pkg::SPP_REG_FSEL_HI: if (wstrb_q[0]) fsel_hi_d = wdata_q[7:0];
        spp_pkg::SPP_REG_CFG_WORD: begin
          if (wstrb_q[0]) cfg_lo_d = wdata_q[7:0];
          if (wstrb_q[1]) cfg_hi_d = wdata_q[15:8];
        end
        spp_pkg::SPP_REG_FSEL_WORD: begin
          if (wstrb_q[0]) fsel_lo_d = wdata_q[7:0];
          if (wstrb_q[1]) fsel_hi_d = wdata_q[15:8];
        end
        spp_pkg::SPP_REG_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= spp_pkg::RESP_OKAY;
      level_q   <= spp_pkg::BYTE_RESET;
      dir_q     <= spp_pkg::BYTE_RESET;
      cfg_lo_q  <= spp_pkg::BYTE_RESET;
      cfg_hi_q  <= spp_pkg::BYTE_RESET;
      fsel_lo_q <= spp_pkg::BYTE_RESET;
      fsel_hi_q <= spp_pkg::BYTE_RESET;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      level_q   <= level_d;
      dir_q     <= dir_d;
      cfg_lo_q  <= cfg_lo_d;
      cfg_hi_q  <= cfg_hi_d;
      fsel_lo_q <= fsel_lo_d;
      fsel_hi_q <= fsel_hi_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // ************************************************************
  // Read channel
  // ************************************************************
  // Input-direction bits show the pin, the rest show the stored value
  assign level_view = {level_q[7:PINS], (dir_q[PINS-1:0] & pad_in)
                       | (~dir_q[PINS-1:0] & level_q[PINS-1:0])};
  assign arready    = !rvalid_q;
  assign rsel       = reg_of(araddr);

  always_comb begin
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = spp_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      unique case (rsel)
        spp_pkg::SPP_REG_LEVEL:     rdata_d[7:0]  = level_view;
        spp_pkg::SPP_REG_DIR:       rdata_d[7:0]  = dir_q;
        spp_pkg::SPP_REG_CFG_LO:    rdata_d[7:0]  = cfg_lo_q;
        spp_pkg::SPP_REG_CFG_HI:    rdata_d[7:0]  = cfg_hi_q;
        spp_pkg::SPP_REG_FSEL_LO:   rdata_d[7:0]  = fsel_lo_q;
        spp_pkg::SPP_REG_FSEL_HI:   rdata_d[7:0]  = fsel_hi_q;
        spp_pkg::SPP_REG_CFG_WORD:  rdata_d[15:0] = {cfg_hi_q, cfg_lo_q};
        spp_pkg::SPP_REG_FSEL_WORD: rdata_d[15:0] = {fsel_hi_q, fsel_lo_q};
        spp_pkg::SPP_REG_NONE:      rresp_d       = spp_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= spp_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else begin
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign rvalid = rvalid_q;
  assign rresp  = rresp_q;
  assign rdata  = rdata_q;

  // ************************************************************
  // Pin cells
  // ************************************************************
  // Pads are registered, so a register change reaches the pin one edge later
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    spp_pkg::spp_pin_ctl_s ctl;
    spp_pkg::spp_pad_s     pad;
    assign ctl = '{dir: dir_q[i], cfg: pair_of(cfg_hi_q, cfg_lo_q, i),
                   func: pair_of(fsel_hi_q, fsel_lo_q, i),
                   func_bad: spp_pkg::FUNC_BAD[i]};
    spp_pin_cell spp_pin_cell_i (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ctl     (ctl),
      .level   (level_q[i]),
      .pad     (pad)
    );
    assign pad_out[i]       = pad.out;
    assign pad_oe_n[i]      = pad.oe_n;
    assign pad_pull_up[i]   = pad.pull_up;
    assign pad_pull_down[i] = pad.pull_down;
  end

  logic [2*PINS-1:0] func_code_q;
  logic [2*PINS-1:0] func_code_d;

  always_comb begin
    func_code_d = {fsel_hi_q[PINS-1:0], fsel_lo_q[PINS-1:0]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_code_q <= '0;
    end else begin
      func_code_q <= func_code_d;
    end
  end

  assign pin_function_code = func_code_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cmos_drive_level: assert property (
    (!dir_q[0] && cfg_hi_q[0] && cfg_lo_q[0] && !fsel_hi_q[0] && !fsel_lo_q[0])
    |=> (!pad_oe_n[0] && pad_out[0] == $past(level_q[0])))
    else $error("cmos output pin not driving level");

  a_read_level_mix: assert property (
    (arvalid && arready && rsel == spp_pkg::SPP_REG_LEVEL)
    |=> rvalid && rdata[PINS-1:0] == (($past(dir_q[PINS-1:0]) & $past(pad_in))
        | (~$past(dir_q[PINS-1:0]) & $past(level_q[PINS-1:0]))))
    else $error("level read mixes pin and store wrongly");

  a_input_reads_pin: assert property (
    (arvalid && arready && rsel == spp_pkg::SPP_REG_LEVEL && dir_q[1])
    |=> rdata[1] == $past(pad_in[1]))
    else $error("input pin level not returned");

  a_dir_write_lands: assert property (
    (do_wr && wsel == spp_pkg::SPP_REG_DIR && wstrb_q[0])
    |=> dir_q == $past(wdata_q[7:0]))
    else $error("direction write lost");

  a_regs_reset_zero: assert property (
    $rose(aresetn) |-> (level_q == 8'h00 && dir_q == 8'h00 && cfg_lo_q == 8'h00
      && cfg_hi_q == 8'h00 && fsel_lo_q == 8'h00 && fsel_hi_q == 8'h00))
    else $error("registers not zero after reset");

  a_hiz_code_release: assert property (
    (!dir_q[2] && !cfg_hi_q[2] && !cfg_lo_q[2]) |=> pad_oe_n[2])
    else $error("hi-z output code drives pin");

  a_pull_down_map: assert property (
    (dir_q[3] && !cfg_hi_q[3] && cfg_lo_q[3] && !fsel_hi_q[3] && !fsel_lo_q[3])
    |=> (pad_pull_down[3] && !pad_pull_up[3] && pad_oe_n[3]))
    else $error("pull-down code not applied");

  a_pch_only_high: assert property (
    (!dir_q[4] && !cfg_hi_q[4] && cfg_lo_q[4] && !fsel_hi_q[4] && !fsel_lo_q[4])
    |=> (pad_oe_n[4] == !$past(level_q[4])))
    else $error("p-channel drive on wrong level");

  a_word_write_both: assert property (
    (do_wr && wsel == spp_pkg::SPP_REG_CFG_WORD && wstrb_q[1:0] == 2'h3)
    |=> {cfg_hi_q, cfg_lo_q} == $past(wdata_q[15:0]))
    else $error("config word write not split into bytes");

  a_write_resp_hold: assert property (
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule : spp_port

// *** testbench/spp_pin_model.sv ***
module spp_pin_model (
  input  wire logic       aclk,
  input  wire logic [5:0] pad_out,
  input  wire logic [5:0] pad_oe_n,
  input  wire logic [5:0] pad_pull_up,
  input  wire logic [5:0] pad_pull_down,
  input  wire logic [5:0] ext_val,
  input  wire logic [5:0] ext_en,
  output logic      [5:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Wire level of each pin
  // ************************************************************
  // A floating pin toggles every cycle so no settled value can pass by luck
  logic [5:0] float_q = 6'h15;

  always @(posedge aclk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pad_oe_n[i]) begin
        pin_level[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else if (pad_pull_up[i]) begin
        pin_level[i] = 1'b1;
      end else if (pad_pull_down[i]) begin
        pin_level[i] = 1'b0;
      end else begin
        pin_level[i] = float_q[i];
      end
    end
  end
endmodule : spp_pin_model

// *** testbench/spp_port_test.sv ***
module spp_port_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Signals
  // ************************************************************
  localparam logic [1:0] OK  = spp_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = spp_pkg::RESP_SLVERR;
  localparam logic [15:0] REGS [8] = '{spp_pkg::IDX_PORT_PIN_LEVEL,
    spp_pkg::IDX_PORT_PIN_DIRECTION, spp_pkg::IDX_PIN_DRIVE_CONFIG_LOW,
    spp_pkg::IDX_PIN_DRIVE_CONFIG_HIGH, spp_pkg::IDX_PIN_FUNC_SELECT_LOW,
    spp_pkg::IDX_PIN_FUNC_SELECT_HIGH, spp_pkg::IDX_PIN_DRIVE_CONFIG_WORD,
    spp_pkg::IDX_PIN_FUNC_SELECT_WORD};
  // Enables expected with level 2A for drive codes 00, 01, 10, 11
  localparam logic [5:0] OE_EXP [4] = '{6'h3F, 6'h15, 6'h2A, 6'h00};

  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [17:0] awaddr  = '0;
  logic [17:0] araddr  = '0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [31:0] wdata   = '0;
  logic [3:0]  wstrb   = 4'hF;
  logic [5:0]  ext_val = '0;
  logic [5:0]  ext_en  = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [5:0]  pad_in, pad_out, pad_oe_n, pad_pull_up, pad_pull_down;
  logic [11:0] func_code;
  logic [1:0]  c;
  int          n_fail  = 0;
  int          checked = 0;

  always #20 aclk = ~aclk;

  spp_port spp_port_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
    .pin_function_code(func_code));

  spp_pin_model spp_pin_model_i (
    .aclk(aclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .ext_val(ext_val), .ext_en(ext_en),
    .pin_level(pad_in));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Readies are combinational from flops, so they are read settled at the falling edge
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    bit         aw_ok;
    bit         w_ok;
    bit         aw_hs;
    bit         w_hs;
    logic       hs;
    logic [1:0] resp;
    int         n;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    n     = 0;
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_ok && w_ok) && n < 100) begin
      @(negedge aclk);
      aw_hs = !aw_ok && (awready === 1'b1);
      w_hs  = !w_ok && (wready === 1'b1);
      @(posedge aclk);
      n++;
      if (aw_hs) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_hs) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Response is accepted one cycle late so the hold check sees a stall
    do begin
      @(negedge aclk);
      hs = bvalid;
      @(posedge aclk);
      n++;
    end while (hs !== 1'b1 && n < 100);
    bready <= 1'b1;
    @(negedge aclk);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    if (n >= 100) n_fail++;
    chk({30'h0, resp}, {30'h0, er});
  endtask : wr

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp,
                        input logic [1:0] er);
    logic        hs;
    logic [31:0] got;
    logic [1:0]  resp;
    int          n;
    n = 0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      hs = arready;
      @(posedge aclk);
      n++;
    end while (hs !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      hs = rvalid;
      @(posedge aclk);
      n++;
    end while (hs !== 1'b1 && n < 100);
    rready <= 1'b1;
    @(negedge aclk);
    got  = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    if (n >= 100) n_fail++;
    chk(got, exp);
    chk({30'h0, resp}, {30'h0, er});
  endtask : rd_chk

  // Pads follow the registers one edge after the write response
  task automatic settle;
    repeat (2) @(posedge aclk);
  endtask : settle

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    #100us;
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd_chk(REGS[i], 32'h0, OK);
    chk({26'h0, pad_oe_n}, 32'h3F);
    $display("test reset done");

    wr(REGS[0], 32'hEA, OK);
    rd_chk(REGS[0], 32'hEA, OK);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(REGS[2], {26'h0, {6{c[0]}}}, OK);
      wr(REGS[3], {26'h0, {6{c[1]}}}, OK);
      settle();
      chk({26'h0, pad_oe_n}, {26'h0, OE_EXP[i]});
      chk({26'h0, pad_out}, 32'h2A);
      chk({20'h0, pad_pull_up, pad_pull_down}, 32'h0);
    end
    $display("test output drive done");

    wr(REGS[1], 32'h3F, OK);
    ext_en <= 6'h3F;
    ext_val <= 6'h15;
    rd_chk(REGS[0], 32'hD5, OK);
    chk({26'h0, pad_oe_n}, 32'h3F);
    ext_en <= 6'h00;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(REGS[6], {18'h0, {6{c[1]}}, 2'b00, {6{c[0]}}}, OK);
      settle();
      chk({26'h0, pad_pull_up}, (c == 2'h2) ? 32'h3F : 32'h0);
      chk({26'h0, pad_pull_down}, (c == 2'h1) ? 32'h3F : 32'h0);
      if (c == 2'h1) rd_chk(REGS[0], 32'hC0, OK);
      if (c == 2'h2) rd_chk(REGS[0], 32'hFF, OK);
    end
    wr(REGS[1], 32'h07, OK);
    ext_en <= 6'h07;
    ext_val <= 6'h05;
    rd_chk(REGS[0], 32'hED, OK);
    $display("test input termination done");

    wr(REGS[6], 32'h2A15, OK);
    rd_chk(REGS[2], 32'h15, OK);
    rd_chk(REGS[3], 32'h2A, OK);
    rd_chk(REGS[6], 32'h2A15, OK);
    wstrb <= 4'h2;
    wr(REGS[6], 32'h0C33, OK);
    wstrb <= 4'hF;
    rd_chk(REGS[6], 32'h0C15, OK);
    wr(REGS[7], 32'h0201, OK);
    rd_chk(REGS[4], 32'h01, OK);
    rd_chk(REGS[5], 32'h02, OK);
    ext_en <= 6'h00;
    wr(REGS[1], 32'h00, OK);
    wr(REGS[6], 32'h3F3F, OK);
    settle();
    chk({20'h0, func_code}, 32'h081);
    chk({26'h0, pad_oe_n}, 32'h03);
    wr(REGS[7], 32'h3020, OK);
    settle();
    chk({20'h0, func_code}, 32'hC20);
    chk({26'h0, pad_oe_n}, 32'h00);
    chk({26'h0, pad_out}, 32'h0A);
    wr(REGS[6], 32'h003F, OK);
    settle();
    chk({26'h0, pad_oe_n}, 32'h35);
    $display("test word access done");

    wr(16'hF216, 32'hFF, ERR);
    rd_chk(16'hF216, 32'h0, ERR);
    rd_chk(REGS[1], 32'h00, OK);
    $display("test unmapped done");
    wrap_up();
  end
endmodule : spp_port_test
